// File: verilog/sac_pkg.sv
// Shared constants, register map and types of the converter sequencer.
// Assumes a 100 MHz APB clock and user logic that follows the timing rules.
//
// What this block does and what its user must keep to
// RULE1 - Mode bit 3 low adds two-tick post-calibration
// RULE2 - Mode bit 2 low powers converter down after conversion
// RULE3 - Mode bits 1:0 select 10, 12 or 8 bits
// RULE4 - Conversion clock period is 4*(1+divider) clocks
// RULE5 - User keeps conversion clock within 0.5-10 MHz
// RULE6 - Start is taken synchronously on a clock edge
// RULE7 - Busy and sample rise when sampling begins
// RULE8 - Sample phase lasts 2+extend conversion ticks
// RULE9 - User honours minimum sample time of monitors
// RULE10 - Distribution drops sample, lasts resolution ticks
// RULE11 - Busy ends after post-calibration or distribution
// RULE12 - Result ready rises with busy fall, holds
// RULE13 - Latency adds one input and output sync
// RULE14 - User should keep post-calibration enabled
// RULE15 - Five-bit channel select, binary channel number
// RULE16 - Result is MSB-justified in twelve bits
// RULE17 - New start abandons running conversion
// RULE18 - Power-up calibration of 3840 ticks, flagged
// RULE19 - Settings captured at start, held throughout

package sac_pkg;

	// ************************************************************
	// Register map and fields
	// ************************************************************
	localparam logic [7:0] OFF_MODE     = 8'h00;
	localparam logic [7:0] OFF_TIMING   = 8'h04;
	localparam logic [7:0] OFF_CTRL     = 8'h08;
	localparam logic [7:0] OFF_STATUS   = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_CLR  = 8'h14;
	localparam logic [7:0] OFF_IRQ_EN   = 8'h18;
	localparam logic [7:0] OFF_RESULT   = 8'h1c;

	localparam int unsigned POSTCAL_OFF_BIT = 3;
	localparam int unsigned KEEP_ON_BIT     = 2;
	localparam int unsigned START_BIT       = 0;
	localparam int unsigned IRQ_W           = 2;
	localparam int unsigned IRQ_DONE_BIT    = 0;
	localparam int unsigned IRQ_CAL_BIT     = 1;

	localparam logic [3:0] MODE_RST   = 4'h0;
	localparam logic [4:0] CHAN_RST   = 5'h00;
	localparam logic [7:0] DIV_RST    = 8'h04;
	localparam logic [7:0] EXT_RST    = 8'h00;

	localparam logic [1:0] RES_10 = 2'h0;
	localparam logic [1:0] RES_12 = 2'h1;
	localparam logic [1:0] RES_8  = 2'h2;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned DIV_MULT      = 4;
	localparam logic [8:0]  SAMPLE_BASE   = 9'h002;
	localparam logic [8:0]  POSTCAL_TICKS = 9'h002;
	localparam int unsigned CAL_TICKS_DEF = 3840;
	localparam int unsigned RESULT_W      = 12;
	localparam logic [11:0] SAR_INIT      = 12'h800;
	localparam logic [4:0]  TEMP_CHANNEL  = 5'h1f;

	typedef struct packed {
		logic [3:0] mode;
		logic [4:0] channel;
		logic [7:0] divide;
		logic [7:0] sample_ext;
	} sac_cfg_t;

	typedef enum logic [4:0] {
		ST_CAL     = 5'h01,
		ST_IDLE    = 5'h02,
		ST_SAMPLE  = 5'h04,
		ST_DIST    = 5'h08,
		ST_POSTCAL = 5'h10
	} sac_state_t;

	// Unused code 11 falls back to ten bits
	function automatic logic [3:0] res_bits(input logic [1:0] code);
		case (code)
			RES_12:  res_bits = 4'hc;
			RES_8:   res_bits = 4'h8;
			RES_10:  res_bits = 4'ha;
			default: res_bits = 4'ha;
		endcase
	endfunction : res_bits

endpackage : sac_pkg

// File: verilog/sac_sync2.sv
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the source holds each level far longer than two clock periods.
`timescale 1ns/1ps

module sac_sync2 #(
	parameter int unsigned W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;

	if (W < 1) begin : g_chk
		$error("sac_sync2: width must be at least one");
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule : sac_sync2

// File: verilog/sac_clk_div.sv
// Conversion clock divider: one-cycle tick every 4*(1+divide) clocks.
// Assumes divide is held stable between restarts.
`timescale 1ns/1ps

module sac_clk_div #(
	parameter int unsigned DIV_W = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             restart,
	input  wire logic [DIV_W-1:0] divide,
	output logic                  tick
);

	logic [DIV_W+1:0] cnt_reg;
	logic [DIV_W+1:0] limit;

	if (DIV_W < 1 || DIV_W > 16) begin : g_chk
		$error("sac_clk_div: divider width out of range");
	end

	// Times four by appending ones: 4*(1+divide)-1
	assign limit = {divide, 2'b11}; // [RULE4]
	assign tick  = (cnt_reg == limit);

	// Restart realigns phases so every conversion starts with a full tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else if (restart || tick) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

endmodule : sac_clk_div

// File: verilog/sac_conv_ctrl.sv
// Sequencer for a successive-approximation converter with an APB slave.
// Assumes a 100 MHz pclk and an asynchronous comparator level on cmp_in.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps

module sac_conv_ctrl #(
	parameter int unsigned CAL_TICKS = sac_pkg::CAL_TICKS_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        cmp_in,
	output logic      [11:0] trial_code,
	output logic      [4:0]  channel_select,
	output logic             internal_temp_strobe,
	output logic             conv_busy,
	output logic             conv_sample,
	output logic             result_ready,
	output logic      [11:0] result,
	output logic             calibrating,
	output logic             power_down
);

	if (CAL_TICKS < 1 || CAL_TICKS > 4095) begin : g_chk
		$error("sac_conv_ctrl: calibration length out of range");
	end

	// ************************************************************
	// Declarations
	// ************************************************************
	sac_pkg::sac_cfg_t   cfg_reg;
	sac_pkg::sac_cfg_t   act_reg;
	sac_pkg::sac_state_t state_reg;
	sac_pkg::sac_state_t state_next;

	logic                      kick_reg;
	logic                      tick;
	logic                      cmp_s;
	logic [8:0]                ph_cnt_reg;
	logic [11:0]               cal_cnt_reg;
	logic [11:0]               trial_reg;
	logic [11:0]               sar_next;
	logic [3:0]                dist_bits;
	logic [3:0]                bitpos;
	logic                      sample_last;
	logic                      dist_last;
	logic                      post_last;
	logic                      postcal_on;
	logic                      conv_done;
	logic                      cal_done;
	logic [4:0]                chan_now;
	logic [sac_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [sac_pkg::IRQ_W-1:0] irq_stat_next;
	logic [sac_pkg::IRQ_W-1:0] irq_en_reg;
	logic [sac_pkg::IRQ_W-1:0] irq_evt;
	logic [sac_pkg::IRQ_W-1:0] irq_clr;
	logic                      acc;
	logic                      wr;
	logic [31:0]               rdata;
	logic                      rerr;

	// ************************************************************
	// APB slave
	// ************************************************************
	// One wait state: pready rises on the second access cycle
	assign acc = psel && penable && pready;
	assign wr  = acc && pwrite;

	always_comb begin
		rdata = 32'h0000_0000;
		rerr  = 1'b0;
		case (paddr)
			sac_pkg::OFF_MODE:     rdata = {19'h0_0000, cfg_reg.channel, 4'h0, cfg_reg.mode};
			sac_pkg::OFF_TIMING:   rdata = {16'h0000, cfg_reg.sample_ext, cfg_reg.divide};
			sac_pkg::OFF_CTRL:     rdata = 32'h0000_0000;
			sac_pkg::OFF_STATUS:   rdata = {4'h0, result, 11'h000, power_down, calibrating,
				result_ready, conv_sample, conv_busy};
			sac_pkg::OFF_IRQ_STAT: rdata = {30'h0000_0000, irq_stat_reg};
			sac_pkg::OFF_IRQ_CLR:  rdata = 32'h0000_0000;
			sac_pkg::OFF_IRQ_EN:   rdata = {30'h0000_0000, irq_en_reg};
			sac_pkg::OFF_RESULT:   rdata = {20'h0_0000, result};
			default:               rerr  = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			prdata  <= (psel && penable && !pready && !pwrite) ? rdata : 32'h0000_0000;
			pslverr <= psel && penable && !pready && rerr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg.mode       <= sac_pkg::MODE_RST;
			cfg_reg.channel    <= sac_pkg::CHAN_RST;
			cfg_reg.divide     <= sac_pkg::DIV_RST;
			cfg_reg.sample_ext <= sac_pkg::EXT_RST;
		end else if (wr && paddr == sac_pkg::OFF_MODE) begin
			cfg_reg.mode    <= pwdata[3:0];
			cfg_reg.channel <= pwdata[12:8]; // [RULE15]
		end else if (wr && paddr == sac_pkg::OFF_TIMING) begin
			cfg_reg.divide     <= pwdata[7:0];
			cfg_reg.sample_ext <= pwdata[15:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_reg <= '0;
		end else if (wr && paddr == sac_pkg::OFF_IRQ_EN) begin
			irq_en_reg <= pwdata[sac_pkg::IRQ_W-1:0];
		end
	end

	// ************************************************************
	// Start capture
	// ************************************************************
	// Registered kick is the one-cycle input sync of the latency
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kick_reg <= 1'b0;
		end else begin
			kick_reg <= wr && paddr == sac_pkg::OFF_CTRL && pwdata[sac_pkg::START_BIT]; // [RULE6] [RULE13]
		end
	end

	// Settings frozen so mid-conversion writes cannot corrupt the result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_reg.mode       <= sac_pkg::MODE_RST;
			act_reg.channel    <= sac_pkg::CHAN_RST;
			act_reg.divide     <= sac_pkg::DIV_RST;
			act_reg.sample_ext <= sac_pkg::EXT_RST;
		end else if (kick_reg) begin
			act_reg <= cfg_reg; // [RULE19]
		end
	end

	sac_clk_div #(
		.DIV_W (8)
	) u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (kick_reg),
		.divide  (act_reg.divide),
		.tick    (tick)
	);

	sac_sync2 #(
		.W (1)
	) u_cmp_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (cmp_in),
		.q       (cmp_s)
	);

	// ************************************************************
	// Sequencer
	// ************************************************************
	assign dist_bits   = sac_pkg::res_bits(act_reg.mode[1:0]); // [RULE3]
	assign postcal_on  = !act_reg.mode[sac_pkg::POSTCAL_OFF_BIT];
	assign sample_last = (ph_cnt_reg == sac_pkg::SAMPLE_BASE + {1'b0, act_reg.sample_ext} - 9'h001);
	assign dist_last   = (ph_cnt_reg == {5'h00, dist_bits - 4'h1});
	assign post_last   = (ph_cnt_reg == sac_pkg::POSTCAL_TICKS - 9'h001);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sac_pkg::ST_CAL: begin
				if (tick && cal_cnt_reg == 12'(CAL_TICKS - 1)) begin
					state_next = sac_pkg::ST_IDLE; // [RULE18]
				end
			end
			sac_pkg::ST_IDLE: begin
				state_next = sac_pkg::ST_IDLE;
			end
			sac_pkg::ST_SAMPLE: begin
				if (tick && sample_last) begin
					state_next = sac_pkg::ST_DIST; // [RULE8]
				end
			end
			sac_pkg::ST_DIST: begin
				if (tick && dist_last) begin
					state_next = postcal_on ? sac_pkg::ST_POSTCAL
						: sac_pkg::ST_IDLE; // [RULE1] [RULE10]
				end
			end
			sac_pkg::ST_POSTCAL: begin
				if (tick && post_last) begin
					state_next = sac_pkg::ST_IDLE; // [RULE11]
				end
			end
			default: begin
				state_next = sac_pkg::ST_IDLE;
			end
		endcase
		// A start in any state drops what is running, calibration included
		if (kick_reg) begin
			state_next = sac_pkg::ST_SAMPLE; // [RULE17]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= sac_pkg::ST_CAL;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_cnt_reg <= 9'h000;
		end else if (kick_reg || state_next != state_reg) begin
			ph_cnt_reg <= 9'h000;
		end else if (tick) begin
			ph_cnt_reg <= ph_cnt_reg + 9'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_cnt_reg <= 12'h000;
		end else if (state_reg == sac_pkg::ST_CAL && tick) begin
			cal_cnt_reg <= cal_cnt_reg + 12'h001; // [RULE18]
		end
	end

	// ************************************************************
	// Successive approximation
	// ************************************************************
	// Trial starts at the MSB so fewer bits leave the low bits zero
	assign bitpos = 4'(sac_pkg::RESULT_W - 1) - ph_cnt_reg[3:0];

	always_comb begin
		sar_next = trial_reg;
		if (!cmp_s) begin
			sar_next[bitpos] = 1'b0;
		end
		if (!dist_last) begin
			sar_next[bitpos - 4'h1] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trial_reg <= 12'h000;
		end else if (state_reg != sac_pkg::ST_DIST && state_next == sac_pkg::ST_DIST) begin
			trial_reg <= sac_pkg::SAR_INIT; // [RULE16]
		end else if (state_reg == sac_pkg::ST_DIST && tick) begin
			trial_reg <= sar_next;
		end
	end

	assign conv_done = !kick_reg && state_next == sac_pkg::ST_IDLE
		&& (state_reg == sac_pkg::ST_DIST || state_reg == sac_pkg::ST_POSTCAL);
	assign cal_done  = state_reg == sac_pkg::ST_CAL && state_next == sac_pkg::ST_IDLE;

	// ************************************************************
	// Status outputs
	// ************************************************************
	// All status taken from state_next so outputs stay flop-driven
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_busy   <= 1'b0;
			conv_sample <= 1'b0;
			calibrating <= 1'b1;
		end else begin
			conv_busy   <= state_next == sac_pkg::ST_SAMPLE || state_next == sac_pkg::ST_DIST
				|| state_next == sac_pkg::ST_POSTCAL; // [RULE7] [RULE11] [RULE13]
			conv_sample <= state_next == sac_pkg::ST_SAMPLE; // [RULE7] [RULE10]
			calibrating <= state_next == sac_pkg::ST_CAL; // [RULE18]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_ready <= 1'b0;
			result       <= 12'h000;
		end else if (kick_reg) begin
			result_ready <= 1'b0;
		end else if (conv_done) begin
			result_ready <= 1'b1; // [RULE12]
			result       <= (state_reg == sac_pkg::ST_DIST) ? sar_next : trial_reg; // [RULE16]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_down <= 1'b0;
		end else if (kick_reg) begin
			power_down <= 1'b0;
		end else if (conv_done) begin
			power_down <= !act_reg.mode[sac_pkg::KEEP_ON_BIT]; // [RULE2]
		end
	end

	assign chan_now = kick_reg ? cfg_reg.channel : act_reg.channel;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_select       <= sac_pkg::CHAN_RST;
			internal_temp_strobe <= 1'b0;
		end else begin
			channel_select       <= chan_now; // [RULE15] [RULE19]
			internal_temp_strobe <= state_next == sac_pkg::ST_SAMPLE
				&& chan_now == sac_pkg::TEMP_CHANNEL;
		end
	end

	assign trial_code = trial_reg;

	// ************************************************************
	// Interrupts
	// ************************************************************
	assign irq_evt = {cal_done, conv_done};
	assign irq_clr = (wr && paddr == sac_pkg::OFF_IRQ_CLR) ? pwdata[sac_pkg::IRQ_W-1:0] : '0;
	// Set beats clear so an event in the clearing cycle survives
	assign irq_stat_next = irq_evt | (irq_stat_reg & ~irq_clr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
			irq         <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq         <= |(irq_stat_next & irq_en_reg);
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	logic [19:0] hlp_cyc;
	logic [19:0] hlp_per;

	assign hlp_per = 20'(sac_pkg::DIV_MULT) * (20'(act_reg.divide) + 20'h00001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hlp_cyc <= 20'h00000;
		end else if (kick_reg || state_next != state_reg) begin
			hlp_cyc <= 20'h00000;
		end else begin
			hlp_cyc <= hlp_cyc + 20'h00001;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_start_status;
		kick_reg |=> conv_busy && conv_sample && !result_ready;
	endproperty
	a_start_status: assert property (p_start_status) else $error("start did not raise status"); // [RULE7]

	property p_sample_time;
		state_reg == sac_pkg::ST_SAMPLE && state_next == sac_pkg::ST_DIST |->
			hlp_cyc == (20'(act_reg.sample_ext) + 20'h00002) * hlp_per - 20'h00001;
	endproperty
	a_sample_time: assert property (p_sample_time) else $error("sample phase length wrong"); // [RULE8]

	property p_dist_time;
		state_reg == sac_pkg::ST_DIST && state_next != sac_pkg::ST_DIST && !kick_reg |->
			hlp_cyc == 20'(dist_bits) * hlp_per - 20'h00001;
	endproperty
	a_dist_time: assert property (p_dist_time) else $error("distribution length wrong"); // [RULE10]

	property p_postcal_path;
		state_reg == sac_pkg::ST_DIST && state_next == sac_pkg::ST_IDLE && !kick_reg |->
			act_reg.mode[sac_pkg::POSTCAL_OFF_BIT];
	endproperty
	a_postcal_path: assert property (p_postcal_path) else $error("post-calibration skipped"); // [RULE1]

	property p_postcal_time;
		state_reg == sac_pkg::ST_POSTCAL && state_next == sac_pkg::ST_IDLE |->
			hlp_cyc == 20'h00002 * hlp_per - 20'h00001;
	endproperty
	a_postcal_time: assert property (p_postcal_time) else $error("post-calibration length wrong"); // [RULE11]

	property p_sample_drop;
		$fell(conv_sample) |-> conv_busy || $past(kick_reg);
	endproperty
	a_sample_drop: assert property (p_sample_drop) else $error("busy fell with sample"); // [RULE10]

	property p_ready_rise;
		$fell(conv_busy) && !$past(kick_reg) |-> result_ready;
	endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("no result ready at busy fall"); // [RULE12]

	property p_ready_hold;
		result_ready && !kick_reg |=> result_ready && $stable(result);
	endproperty
	a_ready_hold: assert property (p_ready_hold) else $error("result ready dropped early"); // [RULE12]

	property p_power_down;
		conv_done && !act_reg.mode[sac_pkg::KEEP_ON_BIT] |=>
			power_down ##1 (power_down || $past(kick_reg));
	endproperty
	a_power_down: assert property (p_power_down) else $error("converter not powered down"); // [RULE2]

	property p_cfg_hold;
		conv_busy && !kick_reg |=> $stable(act_reg) && $stable(channel_select);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed mid-conversion"); // [RULE19]

	property p_cal_time;
		cal_done |-> cal_cnt_reg == 12'(CAL_TICKS - 1) && calibrating;
	endproperty
	a_cal_time: assert property (p_cal_time) else $error("calibration length wrong"); // [RULE18]

	c_done_post: cover property (state_reg == sac_pkg::ST_POSTCAL ##1 result_ready);
	c_done_nopost: cover property (conv_done && state_reg == sac_pkg::ST_DIST);
	c_abandon: cover property (conv_busy && kick_reg);
	c_cal_done: cover property (cal_done);

endmodule : sac_conv_ctrl

// File: test/sac_cmp_model.sv
// Analog front-end model seen by the sequencer: an ideal comparator.
// Assumes the bench holds the analog level steady across a conversion.
`timescale 1ns/1ps

module sac_cmp_model (
	input  wire logic [11:0] analog_level,
	input  wire logic [11:0] trial_code,
	output logic             cmp_in
);
	// ************
	// Comparator
	// ************
	// No offset, so the result is the input truncated to the resolution
	assign cmp_in = (analog_level >= trial_code);
endmodule : sac_cmp_model

// File: test/sac_conv_ctrl_tb_top.sv
// Self-checking bench for the converter sequencer, driven over APB.
// Assumes CAL_TICKS of 4 and the ideal comparator model on cmp_in.
`timescale 1ns/1ps

module sac_conv_ctrl_tb_top;
	// ************
	// Signals
	// ************
	logic        pclk;
	logic        presetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        cmp_in;
	logic [11:0] trial_code;
	logic [4:0]  channel_select;
	logic        internal_temp_strobe;
	logic        conv_busy;
	logic        conv_sample;
	logic        result_ready;
	logic [11:0] result;
	logic        calibrating;
	logic        power_down;
	logic [11:0] analog_level;
	logic [31:0] rd;
	logic        err;
	int          ns;
	int          nr;
	int          ts;
	int          n_mismatch;
	int          n_tests;

	sac_conv_ctrl #(.CAL_TICKS(4)) uut (
		.pclk                 (pclk),
		.presetn              (presetn),
		.paddr                (paddr),
		.psel                 (psel),
		.penable              (penable),
		.pwrite               (pwrite),
		.pwdata               (pwdata),
		.prdata               (prdata),
		.pready               (pready),
		.pslverr              (pslverr),
		.irq                  (irq),
		.cmp_in               (cmp_in),
		.trial_code           (trial_code),
		.channel_select       (channel_select),
		.internal_temp_strobe (internal_temp_strobe),
		.conv_busy            (conv_busy),
		.conv_sample          (conv_sample),
		.result_ready         (result_ready),
		.result               (result),
		.calibrating          (calibrating),
		.power_down           (power_down)
	);

	sac_cmp_model afe (
		.analog_level (analog_level),
		.trial_code   (trial_code),
		.cmp_in       (cmp_in)
	);

	// ************
	// Helpers
	// ************
	task end_sim;
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task tmo;
		chk("timeout", 32'h0, 32'h1);
		end_sim;
	endtask : tmo

	function automatic int nb(input logic [1:0] c);
		return (c == 2'h1) ? 12 : ((c == 2'h2) ? 8 : 10);
	endfunction : nb

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'h1 && i < 50);
		if (i >= 50)
			tmo;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	// Start, then count sample cycles and cycles until ready
	task kick_wait;
		apb(1'h1, sac_pkg::OFF_CTRL, 32'h1);
		ns = 0;
		nr = 0;
		ts = 0;
		while (nr < 3 || result_ready !== 1'h1) begin
			@(posedge pclk);
			#1;
			nr++;
			if (conv_sample === 1'h1)
				ns++;
			if (conv_sample === 1'h1 && internal_temp_strobe === 1'h1)
				ts = 1;
			if (nr == 2) begin
				chk("busy_rise", 32'h3, {conv_busy, conv_sample});
				chk("ready_clr", 32'h0, result_ready);
			end
			if (nr > 3000)
				tmo;
		end
	endtask : kick_wait

	task run(input logic [3:0] m, input logic [7:0] dv, input logic [7:0] ex, input logic [4:0] ch);
		apb(1'h1, sac_pkg::OFF_MODE, {19'h0, ch, 4'h0, m});
		apb(1'h1, sac_pkg::OFF_TIMING, {16'h0, ex, dv});
		kick_wait;
	endtask : run

	// ************
	// Scenarios
	// ************
	task t_regs;
		int n;
		chk("cal_flag", 32'h1, calibrating);
		n = 0;
		while (calibrating !== 1'h0) begin
			@(posedge pclk);
			n++;
			if (n > 1000)
				tmo;
		end
		chk("cal_len", 32'h1, n >= 80 && n <= 84);
		apb(1'h0, sac_pkg::OFF_IRQ_STAT, 32'h0);
		chk("cal_irq", 32'h2, rd);
		apb(1'h0, sac_pkg::OFF_TIMING, 32'h0);
		chk("timing_rst", 32'h4, rd);
		apb(1'h0, sac_pkg::OFF_CTRL, 32'h0);
		chk("ctrl_rd", 32'h0, rd);
		apb(1'h0, 8'h20, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], err});
	endtask : t_regs

	task t_conv;
		logic [3:0] ms [4] = '{4'h0, 4'h1, 4'h6, 4'hd};
		logic [7:0] ds [4] = '{8'h0, 8'h1, 8'h0, 8'h2};
		int         p;
		int         n;
		analog_level = 12'hb6d;
		for (int k = 0; k < 4; k++) begin
			p = 4 * (1 + ds[k]);
			n = nb(ms[k][1:0]);
			run(ms[k], ds[k], 8'(k), 5'(k * 10));
			chk("sample_len", (2 + k) * p, ns);
			// One cycle of start sync; status flops follow the next state
			chk("conv_len", 1 + (2 + k + n + (ms[k][3] ? 0 : 2)) * p, nr);
			chk("result", 12'hb6d & (12'hfff << (12 - n)), result);
			chk("busy_ready", 32'h1, {conv_busy, result_ready});
			chk("power_down", !ms[k][2], power_down);
			chk("channel", k * 10, channel_select);
			chk("strobe_off", 32'h0, ts);
		end
		apb(1'h0, sac_pkg::OFF_RESULT, 32'h0);
		chk("result_reg", 32'hb6d, rd);
	endtask : t_conv

	task t_temp;
		run(4'hc, 8'h0, 8'h1, 5'h1f);
		chk("strobe_on", 32'h1, ts);
		chk("channel31", 32'h1f, channel_select);
	endtask : t_temp

	// Third start lands mid-sample of the second conversion and restarts timing
	task t_abort;
		run(4'h4, 8'h0, 8'h8, 5'h1);
		apb(1'h1, sac_pkg::OFF_CTRL, 32'h1);
		repeat (3) @(posedge pclk);
		kick_wait;
		chk("abort_len", 1 + (10 + 10 + 2) * 4, nr);
		chk("abort_res", 12'hb6c, result);
	endtask : t_abort

	task t_irq;
		apb(1'h1, sac_pkg::OFF_IRQ_CLR, 32'h3);
		apb(1'h1, sac_pkg::OFF_IRQ_EN, 32'h1);
		run(4'hc, 8'h0, 8'h0, 5'h2);
		apb(1'h0, sac_pkg::OFF_IRQ_STAT, 32'h0);
		chk("irq_stat", 32'h1, rd);
		chk("irq_on", 32'h1, irq);
		apb(1'h1, sac_pkg::OFF_IRQ_CLR, 32'h1);
		apb(1'h0, sac_pkg::OFF_IRQ_STAT, 32'h0);
		chk("irq_clr", 32'h0, {rd[30:0], irq});
		apb(1'h1, sac_pkg::OFF_IRQ_EN, 32'h0);
		kick_wait;
		apb(1'h0, sac_pkg::OFF_IRQ_STAT, 32'h0);
		chk("irq_mask", 32'h2, {rd[30:0], irq});
	endtask : t_irq

	// ************
	// Main sequence
	// ************
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		analog_level = 12'h000;
		n_mismatch = 0;
		n_tests = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		#1;
		t_regs;
		t_conv;
		t_temp;
		t_abort;
		t_irq;
		end_sim;
	end
endmodule : sac_conv_ctrl_tb_top
